/* File: hw/ast_pkg.sv */
package ast_pkg;

  // Clock and analog timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned SAMPLE_NS = 100;
  localparam int unsigned SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DECIDE_NS = 25;
  localparam int unsigned DECIDE_CYC = (DECIDE_NS * CLK_MHZ + 999) / 1000;

  // Widths and counts
  localparam int unsigned NCH = 10;
  localparam int unsigned RES_W = 12;
  localparam int unsigned AW = 8;
  localparam logic [3:0] NCH_4 = 4'hA;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TSRC = 8'h04;
  localparam logic [7:0] OFS_START = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CCF = 8'h14;
  localparam logic [7:0] OFS_DIEN = 8'h18;
  localparam logic [7:0] OFS_AUTO_COMPARE_ENABLE = 8'h1C;
  localparam logic [7:0] OFS_CMPHT = 8'h20;
  localparam logic [7:0] OFS_STATE = 8'h24;
  localparam logic [7:0] OFS_RESULT = 8'h40;
  localparam logic [7:0] OFS_RESULT_END = 8'h64;

  // Control register fields
  localparam int unsigned CTRL_CONT_BIT = 0;
  localparam int unsigned CTRL_ETE_BIT = 1;
  localparam int unsigned CTRL_POL_BIT = 2;
  localparam int unsigned CTRL_LVL_BIT = 3;
  localparam int unsigned CTRL_RES_LSB = 4;
  localparam int unsigned CTRL_LEN_LSB = 8;

  // Status and mask fields
  localparam int unsigned ST_SEQ = 0;
  localparam int unsigned ST_CMP = 1;
  localparam int unsigned ST_OVR = 2;

  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0A20;
  localparam logic [3:0] TSRC_RST = 4'h9;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    R_CTRL, R_TSRC, R_START, R_MASK, R_STATUS, R_CCF, R_DIEN, R_AUTO_COMPARE_ENABLE, R_CMPHT, R_STATE, R_RESULT, R_NONE
  } ast_reg_e;

  // Address to register decode, shared by the bus slave and the register file
  function automatic ast_reg_e reg_decode(input logic [7:0] a);
    ast_reg_e r;
    r = R_NONE;
    case (a)
      OFS_CTRL: r = R_CTRL;
      OFS_TSRC: r = R_TSRC;
      OFS_START: r = R_START;
      OFS_MASK: r = R_MASK;
      OFS_STATUS: r = R_STATUS;
      OFS_CCF: r = R_CCF;
      OFS_DIEN: r = R_DIEN;
      OFS_AUTO_COMPARE_ENABLE: r = R_AUTO_COMPARE_ENABLE;
      OFS_CMPHT: r = R_CMPHT;
      OFS_STATE: r = R_STATE;
      default: begin
        if (a >= OFS_RESULT && a <= OFS_RESULT_END && a[1:0] == 2'h0) begin
          r = R_RESULT;
        end
      end
    endcase
    return r;
  endfunction

  // Byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

endpackage

/* File: hw/ast_reg_if.sv */
`timescale 1ns/1ps
interface ast_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;

  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input rd_data);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output rd_data);
endinterface

/* File: hw/ast_axil_slave.sv */
`timescale 1ns/1ps
module ast_axil_slave (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // AXI4-Lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  ast_reg_if.bus rb
);
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [7:0] ar_addr_q;
  logic rd_go_q;
  logic wr_go;

  // Both halves held and no response pending: commit the write
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rb.wr_en = wr_go;
  assign rb.wr_addr = aw_addr_q;
  assign rb.wr_data = w_data_q;
  assign rb.wr_strb = w_strb_q;
  assign rb.rd_en = rd_go_q;
  assign rb.rd_addr = ar_addr_q;

  // Write channels; address and data are taken in either order
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ast_pkg::RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (ast_pkg::reg_decode(aw_addr_q) == ast_pkg::R_NONE) ? ast_pkg::RESP_SLVERR : ast_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel; data is sampled in the cycle the strobe is raised
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ast_pkg::RESP_OKAY;
      ar_addr_q <= 8'h00;
      rd_go_q <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr_q <= s_axi_araddr;
        s_axi_arready <= 1'b0;
        rd_go_q <= 1'b1;
      end
      if (rd_go_q) begin
        rd_go_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rb.rd_data;
        s_axi_rresp <= (ast_pkg::reg_decode(ar_addr_q) == ast_pkg::R_NONE) ? ast_pkg::RESP_SLVERR : ast_pkg::RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

/* File: hw/ast_sar_engine.sv */
`timescale 1ns/1ps
module ast_sar_engine (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Request
  input wire logic i_start,
  input wire logic [3:0] i_chan,
  input wire logic [1:0] i_res,
  output logic o_done,
  output logic [11:0] o_result,
  // Analog front end
  input wire logic i_cmp_gt,
  output logic [3:0] o_mux_sel,
  output logic o_sample,
  output logic o_pwr_up,
  output logic [11:0] o_dac_code
);
  typedef enum logic [1:0] {E_IDLE, E_SAMPLE, E_DECIDE} ast_eng_e;
  ast_eng_e state_q;
  logic [7:0] cnt_q;
  logic [3:0] bit_q;
  logic [3:0] lsb_q;
  logic [11:0] kept;

  // Trial bit is kept when the held sample sits above the trial level
  assign kept = i_cmp_gt ? o_dac_code : (o_dac_code & ~(12'h001 << bit_q));

  // Sample, hold, then one binary-search decision per result bit
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= E_IDLE;
      cnt_q <= 8'h00;
      bit_q <= 4'h0;
      lsb_q <= 4'h0;
      o_done <= 1'b0;
      o_result <= 12'h000;
      o_mux_sel <= 4'h0;
      o_sample <= 1'b0;
      o_pwr_up <= 1'b0;
      o_dac_code <= 12'h000;
    end else begin
      o_done <= 1'b0;
      case (state_q)
        E_IDLE: begin
          if (i_start) begin
            o_mux_sel <= i_chan; // RULE_12
            o_sample <= 1'b1; // RULE_13
            o_pwr_up <= 1'b1; // RULE_11
            cnt_q <= 8'(ast_pkg::SAMPLE_CYC - 1);
            lsb_q <= (i_res == 2'h0) ? 4'h4 : (i_res == 2'h1) ? 4'h2 : 4'h0; // RULE_10
            state_q <= E_SAMPLE;
          end
        end
        E_SAMPLE: begin
          if (cnt_q == 8'h00) begin
            o_sample <= 1'b0; // RULE_13
            bit_q <= 4'hB;
            o_dac_code <= 12'h800;
            cnt_q <= 8'(ast_pkg::DECIDE_CYC - 1);
            state_q <= E_DECIDE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        E_DECIDE: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (bit_q == lsb_q) begin
            o_result <= kept; // RULE_10
            o_dac_code <= 12'h000;
            o_done <= 1'b1;
            o_pwr_up <= 1'b0; // RULE_11
            state_q <= E_IDLE;
          end else begin
            o_dac_code <= kept | (12'h001 << (bit_q - 4'h1));
            bit_q <= bit_q - 4'h1;
            cnt_q <= 8'(ast_pkg::DECIDE_CYC - 1);
          end
        end
        default: state_q <= E_IDLE;
      endcase
    end
  end
endmodule

/* File: hw/ast_adc_ctrl.sv */
// Notes on behaviour
// RULE_01: Trigger off: ignore pin; one sequence, or back-to-back sequences when continuous.
// RULE_02: Edge mode starts exactly one sequence per falling or rising edge by polarity.
// RULE_03: Level mode converts continuously while trigger is at its active level.
// RULE_04: Active edge during a running conversion sets the trigger overrun flag.
// RULE_05: With trigger enabled, the first conversion waits for the trigger.
// RULE_06: With trigger enabled, a start register write does not start a sequence.
// RULE_07: Level mode never sets overrun when trigger toggles mid-sequence.
// RULE_08: Level mode restarts at once if trigger still active at sequence end.
// RULE_09: Trigger source resets to channel 9 and is software selectable.
// RULE_10: Resolution 8, 10 or 12 bits, one SAR decision per bit.
// RULE_11: Converter core is powered down whenever no conversion runs.
// RULE_12: Multiplexer selects exactly one of ten inputs per conversion.
// RULE_13: Input connects to storage node while sampling, disconnects for hold.
// RULE_14: Each pin's digital input buffer is switched by its own enable bit.
// RULE_15: Reset leaves the converter powered down and all registers at reset values.
// RULE_16: Auto compare sets the complete flag only when true; compare interrupt if enabled.
// RULE_17: Start register write clears all complete flags, beating a same-cycle set.
// RULE_18: Sequence end raises an interrupt when enabled; CPU global mask still applies.
// RULE_19: Trigger is synchronised to the bus clock before edge or level detection.
`timescale 1ns/1ps
module ast_adc_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Trigger sources
  input wire logic [9:0] i_an_dig,
  input wire logic [1:0] i_ext_trig,
  // Analog front end
  input wire logic i_cmp_gt,
  output logic [3:0] o_mux_sel,
  output logic o_sample,
  output logic o_pwr_up,
  output logic [11:0] o_dac_code,
  output logic [9:0] o_dig_in_en,
  // Interrupt
  output logic o_irq
);
  typedef enum logic {Q_IDLE, Q_RUN} ast_seq_e;

  ast_reg_if rb ();

  logic [15:0] ctrl_q;
  logic [3:0] tsrc_q;
  logic [3:0] start_ch_q;
  logic [2:0] mask_q;
  logic [2:0] status_q;
  logic [9:0] ccf_q;
  logic [9:0] auto_compare_enable_q;
  logic [9:0] cmpht_q;
  logic [11:0] result_q [ast_pkg::NCH];
  logic soft_pend_q;
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_s3_q;
  ast_seq_e seq_q;
  logic [3:0] idx_q;
  logic irq_q;

  // Control fields
  logic cont;
  logic ete;
  logic pol;
  logic lvl;
  logic [1:0] res;
  logic [3:0] len_raw;
  logic [3:0] seq_len;
  assign cont = ctrl_q[ast_pkg::CTRL_CONT_BIT];
  assign ete = ctrl_q[ast_pkg::CTRL_ETE_BIT];
  assign pol = ctrl_q[ast_pkg::CTRL_POL_BIT];
  assign lvl = ctrl_q[ast_pkg::CTRL_LVL_BIT];
  assign res = ctrl_q[ast_pkg::CTRL_RES_LSB +: 2];
  assign len_raw = ctrl_q[ast_pkg::CTRL_LEN_LSB +: 4];
  // A length of zero or above ten runs all ten conversions
  assign seq_len = (len_raw == 4'h0 || len_raw > ast_pkg::NCH_4) ? ast_pkg::NCH_4 : len_raw;

  // Register decode for both directions
  ast_pkg::ast_reg_e wdec;
  ast_pkg::ast_reg_e rdec;
  logic [31:0] wm;
  logic [31:0] wval_ctrl;
  logic [3:0] widx;
  logic [3:0] ridx;
  logic wr_start;
  logic rd_status;
  assign wdec = ast_pkg::reg_decode(rb.wr_addr);
  assign rdec = ast_pkg::reg_decode(rb.rd_addr);
  assign wm = ast_pkg::strb_mask(rb.wr_strb);
  assign wval_ctrl = (32'(ctrl_q) & ~wm) | (rb.wr_data & wm);
  assign widx = 4'((rb.wr_addr - ast_pkg::OFS_RESULT) >> 2);
  assign ridx = 4'((rb.rd_addr - ast_pkg::OFS_RESULT) >> 2);
  assign wr_start = rb.wr_en && wdec == ast_pkg::R_START;
  assign rd_status = rb.rd_en && rdec == ast_pkg::R_STATUS;

  // Trigger source select; pins 0..9 or the two dedicated trigger inputs
  logic trig_raw;
  assign trig_raw = (tsrc_q < ast_pkg::NCH_4) ? i_an_dig[tsrc_q] : i_ext_trig[tsrc_q[0]]; // RULE_09

  // Two-stage synchroniser, third stage only for edge detection
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= trig_raw; // RULE_19
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  // Polarity applied after the synchroniser
  logic trig_act;
  logic edge_act;
  assign trig_act = pol ? trig_s2_q : !trig_s2_q; // RULE_03
  assign edge_act = pol ? (trig_s2_q && !trig_s3_q) : (!trig_s2_q && trig_s3_q); // RULE_02 RULE_19

  // SAR engine hookup
  logic eng_start;
  logic eng_done;
  logic [11:0] eng_result;
  logic [4:0] ch_sum;
  logic [3:0] eng_chan;
  logic [3:0] next_idx;
  logic run;
  logic last;
  logic seq_end;
  assign next_idx = (run && !seq_end) ? idx_q + 4'h1 : 4'h0;
  assign ch_sum = {1'b0, start_ch_q} + {1'b0, next_idx};
  // Channel wraps modulo ten so each conversion picks exactly one input
  assign eng_chan = (ch_sum >= 5'(ast_pkg::NCH)) ? 4'(ch_sum - 5'(ast_pkg::NCH)) : ch_sum[3:0]; // RULE_12

  ast_sar_engine u_eng (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(eng_start),
    .i_chan(eng_chan),
    .i_res(res),
    .o_done(eng_done),
    .o_result(eng_result),
    .i_cmp_gt(i_cmp_gt),
    .o_mux_sel(o_mux_sel),
    .o_sample(o_sample),
    .o_pwr_up(o_pwr_up),
    .o_dac_code(o_dac_code)
  );

  // Sequence start and continuation decisions
  logic go_ext;
  logic go_soft;
  logic go_idle;
  logic restart;
  logic overrun;
  assign run = seq_q == Q_RUN;
  assign last = idx_q == seq_len - 4'h1;
  assign seq_end = run && eng_done && last;
  // Only the trigger starts conversions once it is enabled
  assign go_ext = ete && (lvl ? trig_act : edge_act); // RULE_02 RULE_03 RULE_05
  assign go_soft = !ete && soft_pend_q; // RULE_01 RULE_06
  assign go_idle = !run && (go_ext || go_soft);
  // Continuous flag matters only with the trigger off; level mode re-checks the pin
  assign restart = seq_end && (ete ? (lvl ? trig_act : edge_act) : cont); // RULE_01 RULE_08
  // Level mode cannot overrun; an edge landing on the final result starts the next run instead
  assign overrun = ete && !lvl && edge_act && run && !seq_end; // RULE_04 RULE_07
  assign eng_start = go_idle || restart || (run && eng_done && !last);

  // Sequencer state
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      seq_q <= Q_IDLE; // RULE_15
      idx_q <= 4'h0;
    end else if (go_idle || restart) begin
      seq_q <= Q_RUN;
      idx_q <= 4'h0;
    end else if (seq_end) begin
      seq_q <= Q_IDLE;
    end else if (run && eng_done) begin
      idx_q <= idx_q + 4'h1;
    end
  end

  // Software start request; ignored entirely while the trigger is enabled
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      soft_pend_q <= 1'b0;
    end else if (ete || go_soft) begin
      soft_pend_q <= 1'b0; // RULE_06
    end else if (wr_start) begin
      soft_pend_q <= 1'b1; // RULE_01
    end
  end

  // Result or compare outcome of the conversion just finished
  logic conv_done;
  logic cmp_on;
  logic cmp_true;
  assign conv_done = run && eng_done;
  assign cmp_on = auto_compare_enable_q[idx_q];
  assign cmp_true = cmpht_q[idx_q] ? (eng_result > result_q[idx_q]) : (eng_result <= result_q[idx_q]);

  logic [9:0] ccf_set;
  logic [2:0] st_set;
  assign ccf_set = (conv_done && (!cmp_on || cmp_true)) ? (10'h001 << idx_q) : 10'h000; // RULE_16
  assign st_set = {overrun, conv_done && cmp_on && cmp_true, seq_end}; // RULE_04 RULE_16 RULE_18

  // Complete flags: start register write wins over a same-cycle set
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ccf_q <= 10'h000;
    end else if (wr_start) begin
      ccf_q <= 10'h000; // RULE_17
    end else begin
      ccf_q <= ccf_q | ccf_set;
    end
  end

  // Sticky events, cleared by reading; a new event beats the clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      status_q <= (rd_status ? 3'h0 : status_q) | st_set;
      irq_q <= |(status_q & mask_q); // RULE_16 RULE_18
    end
  end
  assign o_irq = irq_q;

  // Result store; compare values occupy the same slots and are never overwritten
  genvar g;
  generate
    for (g = 0; g < ast_pkg::NCH; g++) begin : g_res
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          result_q[g] <= 12'h000;
        end else if (rb.wr_en && wdec == ast_pkg::R_RESULT && widx == 4'(g)) begin
          result_q[g] <= rb.wr_data[11:0];
        end else if (conv_done && idx_q == 4'(g) && !auto_compare_enable_q[g]) begin
          result_q[g] <= eng_result; // RULE_16
        end
      end
    end
  endgenerate

  // Software written configuration
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= ast_pkg::CTRL_RST; // RULE_15
      tsrc_q <= ast_pkg::TSRC_RST; // RULE_09
      start_ch_q <= 4'h0;
      mask_q <= 3'h0;
      o_dig_in_en <= 10'h000;
      auto_compare_enable_q <= 10'h000;
      cmpht_q <= 10'h000;
    end else if (rb.wr_en) begin
      case (wdec)
        ast_pkg::R_CTRL: ctrl_q <= wval_ctrl[15:0];
        ast_pkg::R_TSRC: begin
          if (rb.wr_strb[0] && rb.wr_data[3:0] < 4'hC) begin
            tsrc_q <= rb.wr_data[3:0]; // RULE_09
          end
        end
        ast_pkg::R_START: begin
          if (rb.wr_data[3:0] < ast_pkg::NCH_4) begin
            start_ch_q <= rb.wr_data[3:0];
          end
        end
        ast_pkg::R_MASK: mask_q <= rb.wr_data[2:0];
        ast_pkg::R_DIEN: o_dig_in_en <= rb.wr_data[9:0]; // RULE_14
        ast_pkg::R_AUTO_COMPARE_ENABLE: auto_compare_enable_q <= rb.wr_data[9:0];
        ast_pkg::R_CMPHT: cmpht_q <= rb.wr_data[9:0];
        default: ;
      endcase
    end
  end

  // Read data; unmapped addresses read as zero
  always_comb begin
    rb.rd_data = 32'h0000_0000;
    case (rdec)
      ast_pkg::R_CTRL: rb.rd_data = 32'(ctrl_q);
      ast_pkg::R_TSRC: rb.rd_data = 32'(tsrc_q);
      ast_pkg::R_START: rb.rd_data = 32'(start_ch_q);
      ast_pkg::R_MASK: rb.rd_data = 32'(mask_q);
      ast_pkg::R_STATUS: rb.rd_data = 32'(status_q);
      ast_pkg::R_CCF: rb.rd_data = 32'(ccf_q);
      ast_pkg::R_DIEN: rb.rd_data = 32'(o_dig_in_en);
      ast_pkg::R_AUTO_COMPARE_ENABLE: rb.rd_data = 32'(auto_compare_enable_q);
      ast_pkg::R_CMPHT: rb.rd_data = 32'(cmpht_q);
      ast_pkg::R_STATE: rb.rd_data = {27'h0, idx_q, run};
      ast_pkg::R_RESULT: rb.rd_data = 32'(result_q[ridx]);
      default: rb.rd_data = 32'h0000_0000;
    endcase
  end

  ast_axil_slave u_axi (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rb(rb)
  );
endmodule

/* File: verif/ast_assertions.sv */
`timescale 1ns/1ps
module ast_assertions (
  // Clock and reset
  input logic i_clk,
  input logic i_rstn,
  // Bus handshakes
  input logic s_axi_awready,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // Analog front end
  input logic [3:0] o_mux_sel,
  input logic o_sample,
  input logic o_pwr_up,
  input logic [11:0] o_dac_code
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Front end control
  smp_pwr_a: assert property (o_sample |-> o_pwr_up) else $error("sample unpowered");
  pwr_len_a: assert property ($rose(o_pwr_up) |-> ##[40:85] !o_pwr_up) else $error("core stays up");
  mux_range_a: assert property (o_pwr_up |-> o_mux_sel < 4'hA) else $error("bad channel");
  mux_hold_a: assert property (o_pwr_up && $past(o_pwr_up) |-> $stable(o_mux_sel)) else $error("mux moved");
  sample_len_a: assert property ($rose(o_sample) |-> ##19 o_sample ##1 !o_sample) else $error("sample len");
  first_trial_a: assert property ($fell(o_sample) |-> ##[0:1] o_dac_code == 12'h800) else $error("trial");
  // Read answer latency; bus answers hold until taken
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[2:3] s_axi_rvalid) else $error("no rvalid");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata moved");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready early");
  // Main scenarios
  cover property ($fell(o_pwr_up));
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule

/* File: verif/ast_afe_model.sv */
`timescale 1ns/1ps
module ast_afe_model (
  // Clock
  input wire logic i_clk,
  // Converter controls
  input wire logic [3:0] i_mux,
  input wire logic i_smp,
  input wire logic i_pwr,
  input wire logic [11:0] i_dac,
  // Comparator
  output logic o_gt
);
  logic [11:0] held_q;
  logic tog_q = 1'b0;
  // Storage node tracks pin level only while sampling; pin n sits at {n, A5}
  always_ff @(posedge i_clk) begin
    if (i_smp) held_q <= {i_mux, 8'hA5};
    tog_q <= ~tog_q;
  end
  // An unpowered comparator gives no usable answer, so it wanders
  assign o_gt = i_pwr ? (held_q > i_dac) : tog_q;
endmodule

/* File: verif/ast_adc_ctrl_tb.sv */
`timescale 1ns/1ps
module ast_adc_ctrl_tb;
  logic i_clk = 1'b0, i_rstn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, o_mux_sel;
  logic [9:0] i_an_dig = '0, o_dig_in_en;
  logic [1:0] i_ext_trig = '0, s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, i_cmp_gt, o_sample, o_pwr_up, o_irq;
  logic [11:0] o_dac_code;
  logic [31:0] mk [3] = '{32'hFF0, 32'hFFC, 32'hFFE};
  int mismatches = 0, total_checks = 0, cyc = 0, nsmp = 0;
  always #2.5 i_clk = ~i_clk;
  ast_adc_ctrl u_ast_adc_ctrl (.*);
  ast_afe_model u_ast_afe_model (.i_clk, .i_mux(o_mux_sel), .i_smp(o_sample), .i_pwr(o_pwr_up),
    .i_dac(o_dac_code), .o_gt(i_cmp_gt));
  // Count conversions and cut a hang short
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if ($rose(o_sample)) nsmp <= nsmp + 1;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = ast_pkg::RESP_OKAY);
    @(posedge i_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
    input logic [1:0] er = ast_pkg::RESP_OKAY);
    @(posedge i_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Wait until the converter has powered down again
  task automatic idle();
    repeat (8) @(posedge i_clk);
    while (o_pwr_up) @(posedge i_clk);
    repeat (4) @(posedge i_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(ast_pkg::OFS_CTRL, 32'h0A20);
    rd(ast_pkg::OFS_TSRC, 32'h9);
    rd(8'h3C, 32'h0, 32'hFFFFFFFF, ast_pkg::RESP_SLVERR);
    wr(8'h3C, 32'h1, ast_pkg::RESP_SLVERR);
    chk(o_pwr_up, 32'h0);
    $display("reset test done");
    // One software sequence per resolution, interrupt masked for the middle one
    for (int r = 0; r < 3; r++) begin
      wr(ast_pkg::OFS_MASK, {31'h0, r != 1});
      wr(ast_pkg::OFS_CTRL, 32'h100 | (r << 4));
      wr(ast_pkg::OFS_START, r + 3);
      idle();
      chk(nsmp, r + 1);
      chk(o_irq, r != 1);
      rd(ast_pkg::OFS_RESULT, {20'h0, 4'(r + 3), 8'hA5} & mk[r], mk[r]);
      rd(ast_pkg::OFS_CCF, 32'h1);
      rd(ast_pkg::OFS_STATUS, 32'h1);
      rd(ast_pkg::OFS_STATUS, 32'h0);
    end
    wr(ast_pkg::OFS_DIEN, 32'h2AA);
    chk(o_dig_in_en, 32'h2AA);
    chk(o_irq, 32'h0);
    $display("software test done");
    // Edge trigger on the first dedicated pin, both polarities, with a second edge mid-run
    wr(ast_pkg::OFS_TSRC, 32'hA);
    for (int p = 0; p < 2; p++) begin
      i_ext_trig <= {1'b0, !p[0]};
      repeat (8) @(posedge i_clk);
      wr(ast_pkg::OFS_CTRL, 32'h102 | (p << 2));
      wr(ast_pkg::OFS_START, 32'h0);
      repeat (40) @(posedge i_clk);
      chk(nsmp, 3 + p);
      rd(ast_pkg::OFS_CCF, 32'h0);
      i_ext_trig[0] <= p[0];
      repeat (30) @(posedge i_clk);
      i_ext_trig[0] <= !p[0];
      repeat (3) @(posedge i_clk);
      i_ext_trig[0] <= p[0];
      idle();
      chk(nsmp, 4 + p);
      rd(ast_pkg::OFS_STATUS, 32'h5);
    end
    $display("edge test done");
    // Level mode: held trigger restarts, a short drop is no overrun
    i_ext_trig <= 2'h0;
    wr(ast_pkg::OFS_CTRL, 32'h10E);
    repeat (20) @(posedge i_clk);
    chk(nsmp, 32'h5);
    i_ext_trig <= 2'h1;
    repeat (100) @(posedge i_clk);
    i_ext_trig <= 2'h0;
    repeat (2) @(posedge i_clk);
    i_ext_trig <= 2'h1;
    repeat (60) @(posedge i_clk);
    i_ext_trig <= 2'h0;
    idle();
    chk(nsmp >= 8, 32'h1);
    rd(ast_pkg::OFS_STATUS, 32'h0, 32'h4);
    $display("level test done");
    // Auto compare in slot 0: lower-or-same fails, higher-than holds
    wr(ast_pkg::OFS_CTRL, 32'h100);
    wr(ast_pkg::OFS_MASK, 32'h2);
    wr(ast_pkg::OFS_AUTO_COMPARE_ENABLE, 32'h1);
    wr(ast_pkg::OFS_RESULT, 32'h100);
    for (int k = 0; k < 2; k++) begin
      wr(ast_pkg::OFS_CMPHT, k);
      wr(ast_pkg::OFS_START, 32'h3);
      idle();
      chk(o_irq, k);
      rd(ast_pkg::OFS_CCF, k);
      rd(ast_pkg::OFS_STATUS, 32'h1 | (k << 1));
    end
    rd(ast_pkg::OFS_RESULT, 32'h100);
    $display("compare test done");
    results();
  end
endmodule
bind ast_adc_ctrl ast_assertions u_ast_assertions (.*);
